// ==== verif/ecf_link_chk.sv ====
/*
 * Checker for the byte stream between the host end and the device end.
 * Assumes one clock and the link signals handed in as plain inputs.
 */
`timescale 1ns/1ns
`default_nettype none
module ecf_link_chk
	import ecf_pkg::*;
(
	// Clock and reset.
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	// Link signals.
	input  wire logic       valid,
	input  wire logic       ready,
	input  wire logic [7:0] data,
	input  wire logic       last
);
	// ****************************************
	// Frame position trackers
	// ****************************************
	logic        tkn;  // A byte is taken this cycle.
	logic [7:0]  idx;  // Offset of the byte now on the link.
	logic [7:0]  sum;  // Running sum from the frame type on.
	logic [15:0] len;  // Length field as sent.

	assign tkn = valid & ready;

	// The offset restarts after the checksum so back-to-back frames line up.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst)
			idx <= 8'h00;
		else if (tkn)
			idx <= last ? 8'h00 : idx + 8'h01;
	end

	// Only bytes from offset 3 on enter the sum.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst)
			sum <= 8'h00;
		else if (tkn)
			sum <= last ? 8'h00 : (idx >= OFS_FTYPE ? sum + data : sum);
	end

	// The length arrives most significant byte first.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst)
			len <= 16'h0000;
		else if (tkn && idx == OFS_LEN_MSB)
			len[15:8] <= data;
		else if (tkn && idx == OFS_LEN_LSB)
			len[7:0] <= data;
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	start_delim_a: assert property (valid && idx == 8'h00 |-> data == START_DELIM)
		else $error("first byte is not the start delimiter");
	len_msb_a: assert property (valid && idx == OFS_LEN_MSB |-> data == 8'h00)
		else $error("length high byte is not zero");
	len_lsb_a: assert property (valid && idx == OFS_LEN_LSB |-> data >= FIXED_BODY_LEN && data[0])
		else $error("length is not the fixed body plus whole attributes");
	frame_type_a: assert property (valid && idx == OFS_FTYPE |-> data == FRAME_TYPE_EXPL)
		else $error("frame type byte is wrong");
	tx_opt_a: assert property (valid && idx == OFS_TXOPT |-> data == 8'h00)
		else $error("transmit options byte is not zero");
	fctrl_type_a: assert property (valid && idx == OFS_FCTRL |-> data[1:0] == FC_TYPE_GENERAL)
		else $error("frame control type bits are not general");
	cmd_id_a: assert property (valid && idx == OFS_CMD |-> data == CMD_READ_ATTR)
		else $error("command byte is not read attributes");
	csum_val_a: assert property (valid && last |-> data == CSUM_BASE - sum)
		else $error("checksum byte is wrong");
	last_pos_a: assert property (valid && last |-> {8'h00, idx} == len + 16'h0003)
		else $error("checksum does not follow the counted length");
	gap_after_a: assert property (tkn && last |=> !valid)
		else $error("no idle cycle after a frame");

	// Main scenarios seen on the link.
	frame_end_c: cover property (tkn && last);
	radius_zero_c: cover property (valid && idx == OFS_RADIUS && data == 8'h00);
	full_list_c: cover property (valid && last && idx == 8'h2a);
endmodule
`default_nettype wire

// ==== verif/explicit_cluster_cmd_framer_test.sv ====
/*
 * Self-checking bench: host end to device end, plus a faulty driver into a second device.
 * Assumes ecf_pkg, the link interface and both ends are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module explicit_cluster_cmd_framer_test;
	import ecf_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	localparam logic [7:0] HOPS = 8'h0c;  // Non-default hop limit so a hard-wired default shows.
	logic        i_clk = 1'b0;            // Bench clock.
	logic        i_nrst, i_ce, i_start, i_bcast;
	logic [63:0] i_addr64;
	logic [15:0] i_addr16, i_cluster, i_profile;
	logic [7:0]  i_frame_id, i_src_ep, i_dst_ep, i_radius, i_seq;
	logic [3:0]  i_nattr;
	logic [127:0] i_attrs;
	logic        o_done, h_busy, d_bcast, d_rd, d_st, d_ok, d_er, b_st, b_ok, b_er, b_rd;
	logic [63:0] d_a64;
	logic [15:0] d_a16, d_cl, d_pr;
	logic [7:0]  d_src, d_dst, d_rad, d_seq, d_alo, d_ahi, b_rad;
	ecf_err_type d_err, b_err;
	int          n_fail = 0, n_checks = 0, t = 0;
	logic [31:0] seed = 32'hdd5d855d;     // Fixed seed keeps every run alike.

	ecf_link_if lnk_a ();
	ecf_link_if lnk_b ();  // Driven by the bench to break the framing on purpose.

	always #25 i_clk = ~i_clk;

	// ****************************************
	// Design and checker
	// ****************************************
	ecf_host ecf_host_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_start(i_start), .i_bcast(i_bcast),
		.i_addr64(i_addr64), .i_addr16(i_addr16), .i_frame_id(i_frame_id), .i_src_ep(i_src_ep),
		.i_dst_ep(i_dst_ep), .i_cluster(i_cluster), .i_profile(i_profile), .i_radius(i_radius), .i_seq(i_seq),
		.i_nattr(i_nattr), .i_attrs(i_attrs), .o_busy(h_busy), .o_done(o_done), .lnk(lnk_a));
	ecf_device #(.MAX_HOPS(HOPS)) ecf_device_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .lnk(lnk_a),
		.o_addr64(d_a64), .o_addr16(d_a16), .o_bcast(d_bcast), .o_src_ep(d_src), .o_dst_ep(d_dst),
		.o_cluster(d_cl), .o_profile(d_pr), .o_radius(d_rad), .o_seq(d_seq), .o_read_attr(d_rd),
		.o_first_attr_lo(d_alo), .o_first_attr_hi(d_ahi), .o_status_req(d_st), .o_frame_ok(d_ok),
		.o_frame_err(d_er), .o_err(d_err));
	ecf_device #(.MAX_HOPS(HOPS)) ecf_device_inst_b (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .lnk(lnk_b),
		.o_addr64(), .o_addr16(), .o_bcast(), .o_src_ep(), .o_dst_ep(), .o_cluster(), .o_profile(),
		.o_radius(b_rad), .o_seq(), .o_read_attr(b_rd), .o_first_attr_lo(), .o_first_attr_hi(),
		.o_status_req(b_st), .o_frame_ok(b_ok), .o_frame_err(b_er), .o_err(b_err));
	ecf_link_chk ecf_link_chk_inst (.i_clk(i_clk), .i_nrst(i_nrst), .valid(lnk_a.valid), .ready(lnk_a.ready),
		.data(lnk_a.data), .last(lnk_a.last));

	// ****************************************
	// Helpers
	// ****************************************
	// Xorshift generator; a plain sequence is enough to vary the fields.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Field values and verdict flags alike, compared four-state.
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// A wait that ran out ends the run here.
	task automatic hang(input string what);
		n_fail++;
		$display("MISMATCH at %0t: %s", $time, what);
		final_report();
	endtask

	// One request through the host end, then the decoded fields at the device end.
	task automatic run_host(input logic bc, input logic [7:0] r, input logic [7:0] f, input logic [3:0] na);
		int n;
		logic [63:0] ea;
		i_bcast = bc;
		i_radius = r;
		i_frame_id = f;
		i_nattr = na;
		i_addr64 = {rnd(), rnd()};
		i_addr16 = 16'(rnd());
		i_src_ep = 8'(rnd());
		i_dst_ep = 8'(rnd());
		i_cluster = 16'(rnd());
		i_profile = 16'(rnd());
		i_seq = 8'(rnd());
		i_attrs = {rnd(), rnd(), rnd(), rnd()};
		ea = bc ? BCAST_ADDR64 : i_addr64;
		@(negedge i_clk);
		i_start = 1'b1;
		@(negedge i_clk);
		i_start = 1'b0;
		chk(h_busy, 1, "busy during frame");
		for (n = 0; n < 200 && o_done !== 1'b1; n++) @(negedge i_clk);
		if (n == 200) hang("host frame never finished");
		chk(h_busy, 0, "busy after frame");
		chk(d_ok, 1, "frame ok");
		chk(d_er, 0, "frame error");
		chk(d_err, ECF_OK, "verdict");
		chk(d_a64, ea, "long address");
		chk(d_a16, bc ? UNKNOWN_ADDR16 : i_addr16, "short address");
		chk(d_bcast, ea == BCAST_ADDR64, "broadcast");
		chk(d_src, i_src_ep, "source endpoint");
		chk(d_dst, i_dst_ep, "destination endpoint");
		chk(d_cl, i_cluster, "cluster");
		chk(d_pr, i_profile, "profile");
		chk(d_rad, r == 8'h00 ? HOPS : r, "radius");
		chk(d_seq, i_seq, "sequence");
		chk(d_rd, 1, "read attributes");
		chk(d_st, f != 8'h00, "status request");
		if (na != 4'h0) begin
			chk({d_ahi, d_alo}, i_attrs[15:0], "first attribute");
		end
		$display("test %0d done", t++);
	endtask

	// A hand-built frame into the second device, broken as the code asks.
	task automatic send_b(input ecf_err_type code);
		logic [7:0] fb [0:26];
		logic [7:0] s;
		int i;
		int n;
		for (i = 0; i < 26; i++) fb[i] = 8'(rnd());
		fb[0] = (code == ECF_BAD_DELIM) ? 8'h7f : START_DELIM;
		fb[1] = 8'h00;
		fb[2] = (code == ECF_BAD_LEN) ? 8'h18 : FIXED_BODY_LEN;
		fb[3] = (code == ECF_BAD_TYPE) ? 8'h10 : FRAME_TYPE_EXPL;
		fb[21] = 8'h00;
		fb[22] = (code == ECF_BAD_OPT) ? 8'h01 : 8'h00;
		// Frame type bits and command vary so the decode is seen both ways.
		fb[23] = {6'h00, 2'(rnd())};
		fb[25] = (rnd() % 2) ? 8'(rnd()) : CMD_READ_ATTR;
		s = CSUM_BASE;
		for (i = 3; i < 26; i++) s = s - fb[i];
		fb[26] = (code == ECF_BAD_CSUM) ? ~s : s;
		for (i = 0; i < 27; i++) begin
			@(negedge i_clk);
			lnk_b.valid = 1'b1;
			lnk_b.data = fb[i];
			lnk_b.last = (i == 26);
			for (n = 0; n < 20 && lnk_b.ready !== 1'b1; n++) @(negedge i_clk);
			if (n == 20) hang("second device never ready");
		end
		@(negedge i_clk);
		lnk_b.valid = 1'b0;
		lnk_b.last = 1'b0;
		lnk_b.data = ~lnk_b.data;  // A released line must not keep the last byte.
		for (n = 0; n < 5 && b_ok !== 1'b1 && b_er !== 1'b1; n++) @(negedge i_clk);
		if (n == 5) hang("second device gave no verdict");
		chk(b_rd, fb[23][1:0] == FC_TYPE_GENERAL && fb[25] == CMD_READ_ATTR, "command decode");
		chk(b_ok, code == ECF_OK, "faulty frame ok");
		chk(b_er, code != ECF_OK, "faulty frame error");
		chk(b_err, code, "error code");
		chk(b_st, code == ECF_OK && fb[4] != 8'h00, "status");
		if (code == ECF_OK) chk(b_rad, HOPS, "radius default");
		$display("test %0d done", t++);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		i_nrst = 1'b0;
		i_ce = 1'b1;
		i_start = 1'b0;
		{i_bcast, i_addr64, i_addr16, i_frame_id, i_src_ep, i_dst_ep} = '0;
		{i_cluster, i_profile, i_radius, i_seq, i_nattr, i_attrs} = '0;
		{lnk_b.valid, lnk_b.data, lnk_b.last} = '0;
		repeat (12) @(negedge i_clk);
		i_nrst = 1'b1;
		run_host(1'b1, 8'h00, 8'h00, 4'h0);  // Broadcast, network hop limit, no status, empty list.
		run_host(1'b0, 8'hff, 8'hff, 4'h8);  // Full attribute list at the largest radius.
		repeat (12) run_host(1'(rnd()), 8'(rnd()), 8'(rnd()), 4'(rnd() % 9));
		// Reset in mid-frame: both ends drop the frame and come back idle.
		i_start = 1'b1;
		@(negedge i_clk);
		i_start = 1'b0;
		repeat (9) @(negedge i_clk);
		i_nrst = 1'b0;
		@(negedge i_clk);
		chk(lnk_a.valid, 0, "valid in reset");
		i_nrst = 1'b1;
		@(negedge i_clk);
		chk(h_busy, 0, "busy after reset");
		chk(lnk_a.ready, 1, "ready after reset");
		$display("test %0d done", t++);
		run_host(1'b0, 8'h01, 8'h01, 4'h1);  // A whole frame after the cut one.
		for (int c = 0; c < 6; c++) send_b(ecf_err_type'(c));
		final_report();
	end
endmodule
`default_nettype wire

// ==== verilog/ecf_csum.sv ====
/*
 * Running checksum accumulator used by both ends.
 * Assumes the caller marks which bytes fall in the summed span.
 */
`timescale 1ns/1ns
`default_nettype none
module ecf_csum (
	// Clock and reset.
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	input  wire logic       i_ce,
	// Accumulate controls.
	input  wire logic       i_clear,
	input  wire logic       i_add,
	input  wire logic [7:0] i_byte,
	// Result.
	output logic      [7:0] o_csum
);
	import ecf_pkg::*;

	logic [7:0] sum;   // Low eight bits of the running sum.

	// Wraps mod 256 on purpose; only the low byte matters.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sum <= 8'h00;
		end else if (i_ce) begin
			if (i_clear) begin
				sum <= 8'h00;
			end else if (i_add) begin
				sum <= sum + i_byte;
			end
		end
	end

	assign o_csum = CSUM_BASE - sum;
endmodule
`default_nettype wire

// ==== verilog/ecf_device.sv ====
/*
 * Device end: receives and checks an explicit transmit request frame.
 * Assumes the host end drives the link on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module ecf_device #(
	parameter logic [7:0] MAX_HOPS = ecf_pkg::DEF_MAX_HOPS  // Network maximum hops.
) (
	// Clock, reset and enable.
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	input  wire logic       i_ce,
	// Link from the host.
	ecf_link_if.device      lnk,
	// Decoded frame, valid with o_frame_ok or o_frame_err.
	output logic [63:0]     o_addr64,
	output logic [15:0]     o_addr16,
	output logic            o_bcast,
	output logic [7:0]      o_src_ep,
	output logic [7:0]      o_dst_ep,
	output logic [15:0]     o_cluster,
	output logic [15:0]     o_profile,
	output logic [7:0]      o_radius,
	output logic [7:0]      o_seq,
	output logic            o_read_attr,
	output logic [7:0]      o_first_attr_lo,
	output logic [7:0]      o_first_attr_hi,
	output logic            o_status_req,
	// Verdict.
	output logic            o_frame_ok,
	output logic            o_frame_err,
	output var ecf_pkg::ecf_err_type o_err
);
	import ecf_pkg::*;

	logic [7:0]  idx;      // Offset of the incoming byte.
	logic [15:0] len;      // Length field as received.
	logic [7:0]  fid;      // Frame identifier.
	logic [7:0]  fctrl;    // Frame control byte.
	logic [7:0]  csum;     // Expected checksum for this byte position.
	logic        take;     // Byte accepted this cycle.
	ecf_err_type err;      // First fault seen in this frame.

	assign take = lnk.valid && lnk.ready;

	// The device always accepts; frames are checked on the fly.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			lnk.ready <= 1'b0;
		end else if (i_ce) begin
			lnk.ready <= 1'b1;
		end
	end

	// Offset counter, resets after the checksum byte.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			idx <= 8'h00;
		end else if (i_ce && take) begin
			idx <= lnk.last ? 8'h00 : idx + 8'h01;
		end
	end

	// Field capture by offset.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			len             <= 16'h0000;
			fid             <= 8'h00;
			fctrl           <= 8'h00;
			o_addr64        <= 64'h0;
			o_addr16        <= 16'h0000;
			o_src_ep        <= 8'h00;
			o_dst_ep        <= 8'h00;
			o_cluster       <= 16'h0000;
			o_profile       <= 16'h0000;
			o_radius        <= 8'h00;
			o_seq           <= 8'h00;
			o_read_attr     <= 1'b0;
			o_first_attr_lo <= 8'h00;
			o_first_attr_hi <= 8'h00;
		end else if (i_ce && take) begin
			if (idx == OFS_LEN_MSB) begin
				len[15:8] <= lnk.data;
			end
			if (idx == OFS_LEN_LSB) begin
				len[7:0] <= lnk.data;
			end
			if (idx == OFS_FID) begin
				fid <= lnk.data;
			end
			if (idx >= OFS_ADDR64 && idx < OFS_ADDR16) begin
				o_addr64 <= {o_addr64[55:0], lnk.data};
			end
			if (idx == OFS_ADDR16 || idx == OFS_ADDR16 + 8'h01) begin
				o_addr16 <= {o_addr16[7:0], lnk.data};
			end
			if (idx == OFS_SRC_EP) begin
				o_src_ep <= lnk.data;
			end
			if (idx == OFS_DST_EP) begin
				o_dst_ep <= lnk.data;
			end
			if (idx == OFS_CLUSTER || idx == OFS_CLUSTER + 8'h01) begin
				o_cluster <= {o_cluster[7:0], lnk.data};
			end
			if (idx == OFS_PROFILE || idx == OFS_PROFILE + 8'h01) begin
				o_profile <= {o_profile[7:0], lnk.data};
			end
			if (idx == OFS_RADIUS) begin
				// Zero asks for the network limit.
				o_radius <= (lnk.data == 8'h00) ? MAX_HOPS : lnk.data;
			end
			if (idx == OFS_FCTRL) begin
				fctrl <= lnk.data;
			end
			if (idx == OFS_SEQ) begin
				o_seq <= lnk.data;
			end
			if (idx == OFS_CMD) begin
				// Only general frame type gives a general command.
				o_read_attr <= (fctrl[1:0] == FC_TYPE_GENERAL) && (lnk.data == CMD_READ_ATTR);
			end
			if (idx == OFS_PAYLOAD && !lnk.last) begin
				o_first_attr_lo <= lnk.data;
			end
			if (idx == OFS_PAYLOAD + 8'h01 && !lnk.last) begin
				o_first_attr_hi <= lnk.data;
			end
		end
	end

	// Fault tracking: keep the first fault of the frame.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			err <= ECF_OK;
		end else if (i_ce && take) begin
			if (lnk.last) begin
				err <= ECF_OK;
			end else if (err == ECF_OK) begin
				if (idx == 8'h00 && lnk.data != START_DELIM) begin
					err <= ECF_BAD_DELIM;
				end else if (idx == OFS_FTYPE && lnk.data != FRAME_TYPE_EXPL) begin
					err <= ECF_BAD_TYPE;
				end else if (idx == OFS_TXOPT && lnk.data != 8'h00) begin
					err <= ECF_BAD_OPT;
				end
			end
		end
	end

	// Verdict pulses on the checksum byte.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_frame_ok   <= 1'b0;
			o_frame_err  <= 1'b0;
			o_err        <= ECF_OK;
			o_status_req <= 1'b0;
			o_bcast      <= 1'b0;
		end else if (i_ce) begin
			o_frame_ok   <= 1'b0;
			o_frame_err  <= 1'b0;
			o_status_req <= 1'b0;
			if (take && lnk.last) begin
				o_bcast <= (o_addr64 == BCAST_ADDR64);
				if (err != ECF_OK) begin
					o_err       <= err;
					o_frame_err <= 1'b1;
				end else if (len != {8'h00, idx - OFS_FTYPE}) begin
					o_err       <= ECF_BAD_LEN;
					o_frame_err <= 1'b1;
				end else if (lnk.data != csum) begin
					o_err       <= ECF_BAD_CSUM;
					o_frame_err <= 1'b1;
				end else begin
					o_err        <= ECF_OK;
					o_frame_ok   <= 1'b1;
					o_status_req <= (fid != 8'h00);
				end
			end
		end
	end

	// Sum bytes from offset 3 up to the one before the checksum.
	ecf_csum u_csum (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_ce    (i_ce),
		.i_clear (take && lnk.last),
		.i_add   (take && !lnk.last && idx >= OFS_FTYPE),
		.i_byte  (lnk.data),
		.o_csum  (csum)
	);
endmodule
`default_nettype wire

// ==== verilog/ecf_host.sv ====
/*
 * Host end: serialises one Read Attributes request frame onto the link.
 * Assumes the user holds the request fields stable while o_busy is high.
 */
`timescale 1ns/1ns
`default_nettype none
module ecf_host #(
	parameter int NATTR = ecf_pkg::MAX_ATTRS  // Attribute list capacity.
) (
	// Clock, reset and enable.
	input  wire logic           i_clk,
	input  wire logic           i_nrst,
	input  wire logic           i_ce,
	// Request from the user.
	input  wire logic           i_start,
	input  wire logic           i_bcast,
	input  wire logic [63:0]    i_addr64,
	input  wire logic [15:0]    i_addr16,
	input  wire logic [7:0]     i_frame_id,
	input  wire logic [7:0]     i_src_ep,
	input  wire logic [7:0]     i_dst_ep,
	input  wire logic [15:0]    i_cluster,
	input  wire logic [15:0]    i_profile,
	input  wire logic [7:0]     i_radius,
	input  wire logic [7:0]     i_seq,
	input  wire logic [3:0]     i_nattr,
	input  wire logic [NATTR*16-1:0] i_attrs,
	// Status.
	output logic                o_busy,
	output logic                o_done,
	// Link.
	ecf_link_if.host            lnk
);
	import ecf_pkg::*;

	typedef enum {HS_IDLE, HS_SEND} ecf_hstate_type;

	ecf_hstate_type state;       // Sender state.
	logic [7:0]     idx;         // Offset of the next byte to put on the link.
	logic [7:0]     last_ofs;    // Offset of the checksum byte.
	logic [7:0]     cur;         // Byte chosen for this offset.
	logic [7:0]     csum;        // Checksum so far.
	logic           take;        // Byte accepted this cycle.
	logic [63:0]    a64;         // Long address after broadcast override.
	logic [15:0]    a16;         // Short address after broadcast override.
	logic [7:0]     ai;          // Attribute byte index.

	// Broadcast forces both address fields.
	assign a64 = i_bcast ? BCAST_ADDR64 : i_addr64;
	assign a16 = i_bcast ? UNKNOWN_ADDR16 : i_addr16;
	assign take = lnk.valid && lnk.ready;
	assign ai = idx - OFS_PAYLOAD;

	// Byte mux by offset.
	always_comb begin
		cur = 8'h00;
		if (idx == 8'h00) begin
			cur = START_DELIM;
		end else if (idx == OFS_LEN_MSB) begin
			cur = 8'h00;
		end else if (idx == OFS_LEN_LSB) begin
			cur = FIXED_BODY_LEN + {3'h0, i_nattr, 1'b0};
		end else if (idx == OFS_FTYPE) begin
			cur = FRAME_TYPE_EXPL;
		end else if (idx == OFS_FID) begin
			cur = i_frame_id;
		end else if (idx < OFS_ADDR16) begin
			cur = a64[8'd63 - (idx - OFS_ADDR64) * 8 -: 8];
		end else if (idx == OFS_ADDR16) begin
			cur = a16[15:8];
		end else if (idx == OFS_ADDR16 + 8'h01) begin
			cur = a16[7:0];
		end else if (idx == OFS_SRC_EP) begin
			cur = i_src_ep;
		end else if (idx == OFS_DST_EP) begin
			cur = i_dst_ep;
		end else if (idx == OFS_CLUSTER) begin
			cur = i_cluster[15:8];
		end else if (idx == OFS_CLUSTER + 8'h01) begin
			cur = i_cluster[7:0];
		end else if (idx == OFS_PROFILE) begin
			cur = i_profile[15:8];
		end else if (idx == OFS_PROFILE + 8'h01) begin
			cur = i_profile[7:0];
		end else if (idx == OFS_RADIUS) begin
			cur = i_radius;
		end else if (idx == OFS_TXOPT) begin
			cur = 8'h00;
		end else if (idx == OFS_FCTRL) begin
			cur = {6'h00, FC_TYPE_GENERAL};
		end else if (idx == OFS_SEQ) begin
			cur = i_seq;
		end else if (idx == OFS_CMD) begin
			cur = CMD_READ_ATTR;
		end else if (idx < last_ofs) begin
			// Attribute IDs go low byte first.
			cur = i_attrs[ai * 8 +: 8];
		end else begin
			cur = csum;
		end
	end

	// Sequencer: walks offsets and holds each byte until taken.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state     <= HS_IDLE;
			idx       <= 8'h00;
			last_ofs  <= 8'h00;
			lnk.valid <= 1'b0;
			lnk.data  <= 8'h00;
			lnk.last  <= 1'b0;
			o_busy    <= 1'b0;
			o_done    <= 1'b0;
		end else if (i_ce) begin
			o_done <= 1'b0;
			case (state)
				HS_IDLE: begin
					if (i_start) begin
						state    <= HS_SEND;
						idx      <= 8'h00;
						last_ofs <= OFS_PAYLOAD + {3'h0, i_nattr, 1'b0};
						o_busy   <= 1'b1;
					end
				end
				HS_SEND: begin
					// Present the byte for idx, advance once taken.
					if (!lnk.valid || take) begin
						if (take && lnk.last) begin
							lnk.valid <= 1'b0;
							lnk.last  <= 1'b0;
							state     <= HS_IDLE;
							o_busy    <= 1'b0;
							o_done    <= 1'b1;
						end else begin
							lnk.valid <= 1'b1;
							lnk.data  <= cur;
							lnk.last  <= (idx == last_ofs);
							idx       <= idx + 8'h01;
						end
					end
				end
				default: begin
					state <= HS_IDLE;
				end
			endcase
		end
	end

	// Checksum covers bytes from offset 3 up to the one before it.
	ecf_csum u_csum (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_ce    (i_ce),
		.i_clear (state == HS_IDLE),
		.i_add   ((state == HS_SEND) && (!lnk.valid || take) && idx >= OFS_FTYPE && idx < last_ofs),
		.i_byte  (cur),
		.o_csum  (csum)
	);
endmodule
`default_nettype wire

// ==== verilog/ecf_link_if.sv ====
/*
 * Byte stream between the host end and the device end.
 * Assumes one shared clock; the testbench binds the modports.
 */
`timescale 1ns/1ns
`default_nettype none
interface ecf_link_if;
	logic       valid;  // Byte is offered this cycle.
	logic       ready;  // Receiver takes the byte this cycle.
	logic [7:0] data;   // Frame byte.
	logic       last;   // Byte is the checksum.

	// Host sends, device receives.
	modport host   (output valid, output data, output last, input ready);
	modport device (input valid, input data, input last, output ready);
endinterface
`default_nettype wire

// ==== verilog/ecf_pkg.sv ====
/*
 * Shared constants and types for the explicit cluster command framer.
 * Assumes both ends run on one clock and share this package.
 */
package ecf_pkg;
	// ****************************************
	// Frame layout
	// ****************************************
	localparam logic [7:0]  START_DELIM      = 8'h7e;   // Start delimiter value.
	localparam logic [7:0]  FRAME_TYPE_EXPL  = 8'h11;   // Explicit transmit request.
	localparam logic [63:0] BCAST_ADDR64     = 64'h000000000000ffff; // Broadcast long address.
	localparam logic [15:0] UNKNOWN_ADDR16   = 16'hfffe; // Broadcast or unknown short address.
	localparam logic [7:0]  CMD_READ_ATTR    = 8'h00;   // General command Read Attributes.
	localparam logic [1:0]  FC_TYPE_GENERAL  = 2'h0;    // Frame-type bits for general commands.
	localparam logic [7:0]  CSUM_BASE        = 8'hff;   // Checksum is this minus the sum.
	localparam logic [7:0]  OFS_LEN_MSB      = 8'h01;   // Length field offsets.
	localparam logic [7:0]  OFS_LEN_LSB      = 8'h02;
	localparam logic [7:0]  OFS_FTYPE        = 8'h03;   // Frame type, first summed byte.
	localparam logic [7:0]  OFS_FID          = 8'h04;
	localparam logic [7:0]  OFS_ADDR64       = 8'h05;
	localparam logic [7:0]  OFS_ADDR16       = 8'h0d;
	localparam logic [7:0]  OFS_SRC_EP       = 8'h0f;
	localparam logic [7:0]  OFS_DST_EP       = 8'h10;
	localparam logic [7:0]  OFS_CLUSTER      = 8'h11;
	localparam logic [7:0]  OFS_PROFILE      = 8'h13;
	localparam logic [7:0]  OFS_RADIUS       = 8'h15;
	localparam logic [7:0]  OFS_TXOPT        = 8'h16;
	localparam logic [7:0]  OFS_FCTRL        = 8'h17;
	localparam logic [7:0]  OFS_SEQ          = 8'h18;
	localparam logic [7:0]  OFS_CMD          = 8'h19;
	localparam logic [7:0]  OFS_PAYLOAD      = 8'h1a;
	localparam logic [7:0]  FIXED_BODY_LEN   = 8'h17;   // Bytes 3..25 before attributes.
	localparam logic [7:0]  DEF_MAX_HOPS     = 8'h1e;   // Network maximum hop count.
	localparam int          MAX_ATTRS        = 8;       // Attribute list capacity.

	// Checker verdict codes.
	typedef enum logic [2:0] {
		ECF_OK, ECF_BAD_DELIM, ECF_BAD_TYPE, ECF_BAD_OPT, ECF_BAD_CSUM, ECF_BAD_LEN
	} ecf_err_type;
endpackage
